//--- rtl/mpt_timer.sv
// match based pulse timer: prescaler, counter, matches, pulse outputs, capture
`timescale 1ns/1ns
module mpt_timer
  import mpt_pkg::*;
(
  // clock and reset
  input  wire logic                 clock_i,
  input  wire logic                 resetn_i,
  // run control
  input  wire logic                 run_i,
  input  wire logic                 count_reset_i,
  input  wire logic                 pwm_en_i,
  input  wire logic [TC_W-1:0]      prescale_i,
  // counter mode
  input  wire logic                 counter_mode_i,
  input  wire logic                 count_src_i,
  input  wire logic [1:0]           count_edge_i,
  // match shadow writes and release
  input  wire logic                 match_wr_i,
  input  wire logic [IDX_W-1:0]     match_idx_i,
  input  wire logic [TC_W-1:0]      match_val_i,
  input  wire logic [NUM_MATCH-1:0] release_i,
  // match actions
  input  wire logic [NUM_MATCH-1:0] match_int_i,
  input  wire logic [NUM_MATCH-1:0] match_reset_i,
  input  wire logic [NUM_MATCH-1:0] match_stop_i,
  // pulse output config
  input  wire logic [NUM_OUT:1]     out_en_i,
  input  wire logic [NUM_OUT:2]     out_double_i,
  // capture inputs
  input  wire logic [NUM_CAP-1:0]   cap_i,
  input  wire logic [NUM_CAP-1:0]   cap_rise_en_i,
  input  wire logic [NUM_CAP-1:0]   cap_fall_en_i,
  input  wire logic [NUM_CAP-1:0]   cap_int_i,
  // status and outputs
  output logic [TC_W-1:0]           count_o,
  output logic [TC_W-1:0]           cap0_o,
  output logic [TC_W-1:0]           cap1_o,
  output logic [NUM_OUT:1]          pwm_o,
  output logic [NUM_MATCH-1:0]      match_flag_o,
  output logic [NUM_CAP-1:0]        cap_flag_o,
  output logic [NUM_MATCH-1:0]      release_pend_o,
  output logic                      running_o,
  output logic                      halted_o
);
  // ****************************************************************
  // state
  // ****************************************************************
  mpt_state_t                 state_reg, state_next;
  logic [TC_W-1:0]            pc_reg, pc_next;
  logic [TC_W-1:0]            tc_reg, tc_next;
  logic [TC_W-1:0]            shadow_reg [NUM_MATCH];
  logic [TC_W-1:0]            shadow_next [NUM_MATCH];
  logic [TC_W-1:0]            active_reg [NUM_MATCH];
  logic [TC_W-1:0]            active_next [NUM_MATCH];
  logic [NUM_MATCH-1:0]       pend_reg, pend_next;
  logic [NUM_OUT:1]           out_reg, out_next;
  logic [NUM_MATCH-1:0]       mflag_reg, mflag_next;
  logic [TC_W-1:0]            cap_reg [NUM_CAP];
  logic [TC_W-1:0]            cap_next [NUM_CAP];
  logic [NUM_CAP-1:0]         cflag_reg, cflag_next;
  logic [NUM_CAP-1:0]         rise, fall;
  logic [NUM_MATCH-1:0]       hit;
  logic                       tick, src_rise, src_fall, cycle_hit, xfer;

  // compare of one active match against the count, used per match
  function automatic logic match_eq(input logic [TC_W-1:0] a, input logic [TC_W-1:0] b);
    match_eq = (a == b);
  endfunction

  // ****************************************************************
  // capture edge detectors
  // ****************************************************************
  for (genvar c = 0; c < NUM_CAP; c++) begin : g_edge
    mpt_edge u_edge (
      .clock_i  (clock_i),
      .resetn_i (resetn_i),
      .sig_i    (cap_i[c]),
      .rise_o   (rise[c]),
      .fall_o   (fall[c])
    );
  end

  // ****************************************************************
  // count advance and match detection
  // ****************************************************************
  // counter mode bypasses the prescaler, as the edges are already slow
  always_comb begin
    src_rise = count_src_i ? rise[1] : rise[0];
    src_fall = count_src_i ? fall[1] : fall[0];
    if (counter_mode_i) begin
      tick = (state_reg == ST_RUN) &&
             ((count_edge_i[0] && src_rise) || (count_edge_i[1] && src_fall));
    end else begin
      tick = (state_reg == ST_RUN) && (pc_reg == prescale_i);
    end
    for (int k = 0; k < NUM_MATCH; k++) begin
      hit[k] = tick && match_eq(tc_reg, active_reg[k]);
    end
    cycle_hit = pwm_en_i && hit[0];
    xfer      = pwm_en_i ? cycle_hit : 1'b1;
  end

  // run state, prescaler and counter
  always_comb begin
    state_next = state_reg;
    pc_next    = pc_reg;
    tc_next    = tc_reg;
    case (state_reg)
      ST_IDLE: begin
        if (run_i && !count_reset_i) state_next = ST_RUN;
      end
      ST_RUN: begin
        if (!run_i) state_next = ST_IDLE;
        else if (|(hit & match_stop_i)) state_next = ST_HALT;
      end
      ST_HALT: begin
        if (!run_i || count_reset_i) state_next = ST_IDLE;
      end
      default: state_next = ST_IDLE;
    endcase
    if (count_reset_i) begin
      pc_next = TC_RST;
      tc_next = TC_RST;
    end else if (state_reg == ST_RUN) begin
      pc_next = (tick || counter_mode_i) ? TC_RST : pc_reg + 32'h0000_0001;
      if (cycle_hit || |(hit & match_reset_i)) begin
        tc_next = TC_RST;
        pc_next = TC_RST;
      end else if (tick && !(|(hit & match_stop_i))) begin
        tc_next = tc_reg + 32'h0000_0001;
      end
    end
  end

  // ****************************************************************
  // shadow, release and active match values
  // ****************************************************************
  // a release in the transfer cycle stays pending: set wins over clear
  always_comb begin
    for (int k = 0; k < NUM_MATCH; k++) begin
      shadow_next[k] = shadow_reg[k];
      active_next[k] = active_reg[k];
      if (match_wr_i && (match_idx_i == IDX_W'(k))) shadow_next[k] = match_val_i;
      if (pend_reg[k] && xfer) active_next[k] = shadow_reg[k];
    end
    pend_next = (pend_reg & ~(xfer ? pend_reg : FLAG_RST)) | release_i;
  end

  // ****************************************************************
  // pulse outputs and match flags
  // ****************************************************************
  // clear wins over set so a zero width output stays constant low
  always_comb begin
    logic             set_b;
    logic             clr_b;
    logic [NUM_OUT:1] dbl_b;
    set_b    = 1'b0;
    clr_b    = 1'b0;
    dbl_b    = {out_double_i, 1'b0}; // output 1 has no rise match of its own
    out_next = out_reg;
    for (int n = 1; n <= NUM_OUT; n++) begin
      if (dbl_b[n]) begin
        set_b = hit[n-1];
      end else begin
        set_b = hit[0];
      end
      clr_b = hit[n];
      if (!pwm_en_i || !out_en_i[n]) out_next[n] = 1'b0;
      else if (clr_b) out_next[n] = 1'b0;
      else if (set_b) out_next[n] = 1'b1;
    end
    mflag_next = hit & match_int_i;
  end

  // ****************************************************************
  // capture
  // ****************************************************************
  always_comb begin
    for (int c = 0; c < NUM_CAP; c++) begin
      cap_next[c]   = cap_reg[c];
      cflag_next[c] = 1'b0;
      if ((rise[c] && cap_rise_en_i[c]) || (fall[c] && cap_fall_en_i[c])) begin
        cap_next[c]   = tc_reg;
        cflag_next[c] = cap_int_i[c];
      end
    end
  end

  // ****************************************************************
  // registers
  // ****************************************************************
  always_ff @(posedge clock_i) begin
    if (!resetn_i) begin
      state_reg <= ST_IDLE;
      pc_reg    <= TC_RST;
      tc_reg    <= TC_RST;
      pend_reg  <= FLAG_RST;
      out_reg   <= OUT_RST;
      mflag_reg <= FLAG_RST;
      cflag_reg <= '0;
      for (int k = 0; k < NUM_MATCH; k++) begin
        shadow_reg[k] <= TC_RST;
        active_reg[k] <= TC_RST;
      end
      for (int c = 0; c < NUM_CAP; c++) begin
        cap_reg[c] <= TC_RST;
      end
    end else begin
      state_reg  <= state_next;
      pc_reg     <= pc_next;
      tc_reg     <= tc_next;
      pend_reg   <= pend_next;
      out_reg    <= out_next;
      mflag_reg  <= mflag_next;
      cflag_reg  <= cflag_next;
      shadow_reg <= shadow_next;
      active_reg <= active_next;
      cap_reg    <= cap_next;
    end
  end

  assign count_o        = tc_reg;
  assign cap0_o         = cap_reg[0];
  assign cap1_o         = cap_reg[1];
  assign pwm_o          = out_reg;
  assign match_flag_o   = mflag_reg;
  assign cap_flag_o     = cflag_reg;
  assign release_pend_o = pend_reg;
  assign running_o      = state_reg[1];
  assign halted_o       = state_reg[2];

  // ****************************************************************
  // checks
  // ****************************************************************
  sequence seq_cycle_start;
    pwm_en_i && hit[0] && !count_reset_i;
  endsequence

  sequence seq_out1_rise;
    seq_cycle_start ##0 (out_en_i[1] && !hit[1]);
  endsequence

  chk_prescale_tick: assert property (@(posedge clock_i) disable iff (!resetn_i)
    (state_reg == ST_RUN && !counter_mode_i && !count_reset_i) |=>
    (pc_reg == (($past(pc_reg) == $past(prescale_i)) ? TC_RST :
                $past(pc_reg) + 32'h0000_0001)))
    else $error("prescaler did not step or wrap at the prescale value");

  chk_cycle_reset: assert property (@(posedge clock_i) disable iff (!resetn_i)
    seq_cycle_start |=> (tc_reg == TC_RST))
    else $error("count not reset by cycle match");

  chk_single_rise: assert property (@(posedge clock_i) disable iff (!resetn_i)
    seq_out1_rise |=> pwm_o[1])
    else $error("single edge output did not rise at cycle start");

  chk_const_low: assert property (@(posedge clock_i) disable iff (!resetn_i)
    hit[1] |=> !pwm_o[1])
    else $error("output high after its own fall match");

  chk_double_rise: assert property (@(posedge clock_i) disable iff (!resetn_i)
    (pwm_en_i && out_en_i[3] && out_double_i[3] && hit[2] && !hit[3]) |=> pwm_o[3])
    else $error("double edge output missed its rise");

  chk_release_hold: assert property (@(posedge clock_i) disable iff (!resetn_i)
    (pwm_en_i && !hit[0]) |=> (active_reg[3] == $past(active_reg[3])))
    else $error("match value changed mid cycle");

  chk_stop_halt: assert property (@(posedge clock_i) disable iff (!resetn_i)
    (state_reg == ST_RUN && run_i && |(hit & match_stop_i)) |=> halted_o ##1 !running_o)
    else $error("stop on match did not halt timer");

  chk_capture_copy: assert property (@(posedge clock_i) disable iff (!resetn_i)
    (rise[0] && cap_rise_en_i[0]) |=> (cap0_o == $past(tc_reg)))
    else $error("capture did not copy the count");

  chk_timer_step: assert property (@(posedge clock_i) disable iff (!resetn_i)
    (tick && !count_reset_i && !cycle_hit && !(|(hit & (match_reset_i | match_stop_i))))
    |=> (tc_reg == $past(tc_reg) + 32'h0000_0001))
    else $error("timer did not advance by one");
endmodule

//--- rtl/mpt_pkg.sv
// package of constants and types for the match based pulse timer
// What this block does
// - with pulse mode off it is a plain 32-bit timer behind a 32-bit prescaler
// - seven match registers give six single-edge or three double-edge outputs, or mixes
// - a cycle match resets the count and starts a new shared cycle
// - single-edge outputs rise at cycle start, fall at their own match
// - an output held constant low never rises at cycle start
// - double-edge outputs: one match sets rise, another fall; either order
// - single-edge uses one match, double-edge two; all share the cycle match
// - each match may keep counting, stop, or reset, with optional interrupt
// - new match values wait for a software release, then apply glitch-free
// - timer counts clocks; counter mode counts edges of a selected capture input
// - period and width are any count; all outputs share one rate
// - a match can switch pins, raise interrupts or trigger other actions
// - a capture input edge copies the count, optionally raising an interrupt
package mpt_pkg;
  // ****************************************************************
  // widths and counts
  // ****************************************************************
  localparam int TC_W      = 32;
  localparam int NUM_MATCH = 7;
  localparam int NUM_OUT   = 6;
  localparam int NUM_CAP   = 2;
  localparam int IDX_W     = 3;

  // ****************************************************************
  // reset values
  // ****************************************************************
  localparam logic [TC_W-1:0]      TC_RST    = 32'h0000_0000;
  localparam logic [NUM_MATCH-1:0] FLAG_RST  = 7'h00;
  localparam logic [NUM_OUT:1]     OUT_RST   = 6'h00;

  // ****************************************************************
  // counter mode edge select
  // ****************************************************************
  localparam logic [1:0] EDGE_RISE = 2'h1;
  localparam logic [1:0] EDGE_FALL = 2'h2;
  localparam logic [1:0] EDGE_BOTH = 2'h3;

  // ****************************************************************
  // timer run state, one-hot
  // ****************************************************************
  typedef enum logic [2:0] {
    ST_IDLE = 3'h1,
    ST_RUN  = 3'h2,
    ST_HALT = 3'h4
  } mpt_state_t;
endpackage

//--- rtl/mpt_edge.sv
// edge detector for one synchronous input
`timescale 1ns/1ns
module mpt_edge
  import mpt_pkg::*;
(
  // clock and reset
  input  wire logic clock_i,
  input  wire logic resetn_i,
  // sampled level and edges
  input  wire logic sig_i,
  output logic      rise_o,
  output logic      fall_o
);
  logic prev_reg;
  logic prev_next;

  // previous level, inputs already synchronous
  always_comb begin
    prev_next = sig_i;
  end

  always_ff @(posedge clock_i) begin
    if (!resetn_i) begin
      prev_reg <= 1'b0;
    end else begin
      prev_reg <= prev_next;
    end
  end

  // edges are combinational pulses, one cycle wide
  assign rise_o = sig_i & ~prev_reg;
  assign fall_o = ~sig_i & prev_reg;
endmodule

//--- verif/mpt_load.sv
// load model on the pulse outputs: high time of each output over a window
`timescale 1ns/1ns
module mpt_load
  import mpt_pkg::*;
(
  // clock
  input  wire logic                  clock_i,
  // pulse outputs and measure window
  input  wire logic [NUM_OUT:1]      pwm_i,
  input  wire logic                  win_i,
  // high clocks seen per output
  output logic [NUM_OUT:1][TC_W-1:0] hi_o
);
  // ****************************************************************
  // duty measurement
  // ****************************************************************
  logic win_reg = 1'b0;

  // restart on window open, so the window may start at any phase of a cycle
  always_ff @(posedge clock_i) begin
    win_reg <= win_i;
    for (int n = 1; n <= NUM_OUT; n++) begin
      if (win_i && !win_reg) begin
        hi_o[n] <= TC_W'(pwm_i[n]);
      end else if (win_i) begin
        hi_o[n] <= hi_o[n] + TC_W'(pwm_i[n]);
      end
    end
  end
endmodule

//--- verif/testbench.sv
// self-checking bench for the match based pulse timer
`timescale 1ns/1ns
module testbench;
  import mpt_pkg::*;
  // ****************************************************************
  // stimulus and observed signals
  // ****************************************************************
  logic                            clock_i = 0, resetn_i = 0, run_i = 0, count_reset_i = 0;
  logic                            pwm_en_i = 0, counter_mode_i = 0, count_src_i = 0;
  logic                            match_wr_i = 0, win_i = 0;
  logic [1:0]                      count_edge_i = 0;
  logic [TC_W-1:0]                 prescale_i = 0, match_val_i = 0;
  logic [IDX_W-1:0]                match_idx_i = 0;
  logic [NUM_MATCH-1:0]            release_i = 0, match_int_i = 0, match_reset_i = 0;
  logic [NUM_MATCH-1:0]            match_stop_i = 0, match_flag_o, release_pend_o;
  logic [NUM_OUT:1]                out_en_i = 0, pwm_o;
  logic [NUM_OUT:2]                out_double_i = 0;
  logic [NUM_CAP-1:0]              cap_i = 0, cap_rise_en_i = 0, cap_fall_en_i = 0;
  logic [NUM_CAP-1:0]              cap_int_i = 0, cap_flag_o;
  logic [TC_W-1:0]                 count_o, cap0_o, cap1_o;
  logic                            running_o, halted_o;
  logic [NUM_OUT:1][TC_W-1:0]      hi;
  int                              err_total = 0, n_checks = 0, cyc = 0;
  int                              flag_cnt = 0, capf_cnt = 0, pre, per, nv, nr;
  int                              m [0:6] = '{9, 3, 2, 6, 7, 1, 9};

  // clock
  always #5 clock_i = ~clock_i;

  mpt_timer DUT (.clock_i, .resetn_i, .run_i, .count_reset_i, .pwm_en_i, .prescale_i,
    .counter_mode_i, .count_src_i, .count_edge_i, .match_wr_i, .match_idx_i, .match_val_i,
    .release_i, .match_int_i, .match_reset_i, .match_stop_i, .out_en_i, .out_double_i,
    .cap_i, .cap_rise_en_i, .cap_fall_en_i, .cap_int_i, .count_o, .cap0_o, .cap1_o, .pwm_o,
    .match_flag_o, .cap_flag_o, .release_pend_o, .running_o, .halted_o);

  mpt_load u_load (.clock_i, .pwm_i(pwm_o), .win_i, .hi_o(hi));

  // event counters and hang guard; flags stand one cycle only
  always @(posedge clock_i) begin
    cyc <= cyc + 1;
    if (match_flag_o[1] === 1'b1) flag_cnt++;
    if (cap_flag_o[0] === 1'b1) capf_cnt++;
    if (cyc == 20000) begin
      err_total++;
      stop_test();
    end
  end

  // ****************************************************************
  // reference model and helpers
  // ****************************************************************
  // high counts per cycle of output n, from the match table
  function automatic int exp_hi(int n);
    int r;
    int f;
    r = m[n-1];
    f = m[n];
    if (n == 1 || !out_double_i[n]) return (m[n] == m[0]) ? 0 : m[n] + 1;
    return (f > r) ? f - r : m[0] + 1 - (r - f);
  endfunction

  task automatic chk(logic [31:0] seen, logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic tick(int n);
    repeat (n) @(posedge clock_i);
  endtask

  task automatic wr_match(int idx, int val);
    tick(1);
    match_wr_i  <= 1'b1;
    match_idx_i <= IDX_W'(idx);
    match_val_i <= TC_W'(val);
    tick(1);
    match_wr_i  <= 1'b0;
  endtask

  task automatic rel(logic [NUM_MATCH-1:0] mask);
    tick(1);
    release_i <= mask;
    tick(1);
    release_i <= '0;
  endtask

  // whole cycles in the window, so phase does not matter
  task automatic measure();
    tick(1);
    win_i <= 1'b1;
    tick(4 * per);
    win_i <= 1'b0;
    tick(2);
    @(negedge clock_i);
    for (int n = 1; n <= NUM_OUT; n++) chk(hi[n], 4 * (pre + 1) * exp_hi(n));
  endtask

  task automatic stop_test();
    $display("checks %0d errors %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  // ****************************************************************
  // main sequence
  // ****************************************************************
  initial begin
    void'($urandom(14));
    tick(10);
    resetn_i <= 1'b1;
    @(negedge clock_i);
    chk(count_o, 0);
    chk({pwm_o, running_o, halted_o}, 0);
    // plain timer: exactly one count per prescale period
    pre = $urandom_range(0, 3);
    tick(1);
    prescale_i <= TC_W'(pre);
    run_i      <= 1'b1;
    tick(5);
    @(negedge clock_i);
    nr = count_o;
    tick((pre + 1) * 20);
    @(negedge clock_i);
    chk(count_o, nr + 20);
    chk(running_o, 1);
    // stop on match with interrupt flag
    tick(1);
    run_i         <= 1'b0;
    count_reset_i <= 1'b1;
    wr_match(1, 12);
    rel(7'h02);
    match_stop_i  <= 7'h02;
    match_int_i   <= 7'h02;
    count_reset_i <= 1'b0;
    run_i         <= 1'b1;
    tick((pre + 1) * 14 + 10);
    @(negedge clock_i);
    chk(count_o, 32'hC);
    chk(halted_o, 1);
    chk(flag_cnt, 1);
    // reset on match 1 (value 12): count wraps, 13 counts a turn
    tick(1);
    run_i         <= 1'b0;
    count_reset_i <= 1'b1;
    match_stop_i  <= '0;
    match_int_i   <= '0;
    match_reset_i <= 7'h02;
    tick(2);
    count_reset_i <= 1'b0;
    run_i         <= 1'b1;
    tick(1 + 20 * (pre + 1));
    @(negedge clock_i);
    chk(count_o, 20 % 13);
    chk(halted_o, 0);
    // pulse mode with single, double and constant low outputs
    tick(1);
    run_i         <= 1'b0;
    match_reset_i <= '0;
    match_stop_i  <= '0;
    match_int_i   <= '0;
    count_reset_i <= 1'b1;
    pre = $urandom_range(0, 2);
    per = (m[0] + 1) * (pre + 1);
    prescale_i <= TC_W'(pre);
    for (int k = 0; k < NUM_MATCH; k++) wr_match(k, m[k]);
    rel(7'h7F);
    out_en_i      <= 6'h3F;
    out_double_i  <= 5'h0A;
    pwm_en_i      <= 1'b1;
    count_reset_i <= 1'b0;
    run_i         <= 1'b1;
    tick(3 * per);
    measure();
    // unreleased value has no effect; released one lands at cycle start
    nv = $urandom_range(4, 8);
    wr_match(1, nv);
    measure();
    rel(7'h02);
    @(negedge clock_i);
    chk(release_pend_o, 7'h02);
    m[1] = nv;
    tick(per + 2);
    @(negedge clock_i);
    chk(release_pend_o, 0);
    measure();
    // counter mode on rising edges of capture input 1
    tick(1);
    run_i          <= 1'b0;
    pwm_en_i       <= 1'b0;
    count_reset_i  <= 1'b1;
    counter_mode_i <= 1'b1;
    count_src_i    <= 1'b1;
    count_edge_i   <= 2'h1;
    tick(2);
    count_reset_i  <= 1'b0;
    run_i          <= 1'b1;
    nr = $urandom_range(3, 9);
    repeat (nr) begin
      tick(3);
      cap_i[1] <= 1'b1;
      tick(3);
      cap_i[1] <= 1'b0;
    end
    tick(4);
    @(negedge clock_i);
    chk(count_o, nr);
    // capture on rise of input 0, which is not the count source
    tick(1);
    cap_rise_en_i <= 2'h1;
    cap_int_i     <= 2'h1;
    cap_i[0]      <= 1'b1;
    tick(3);
    @(negedge clock_i);
    chk(cap0_o, nr);
    chk(count_o, nr);
    chk(capf_cnt, 1);
    // capture on fall of input 1
    tick(1);
    cap_fall_en_i <= 2'h2;
    cap_i[1]      <= 1'b1;
    tick(3);
    cap_i[1]      <= 1'b0;
    tick(3);
    @(negedge clock_i);
    chk(cap1_o, nr + 1);
    // falling edges only, then both edges, through the package codes
    tick(1);
    count_edge_i <= EDGE_FALL;
    repeat (2) begin
      tick(2);
      cap_i[1] <= 1'b1;
      tick(2);
      cap_i[1] <= 1'b0;
    end
    tick(3);
    @(negedge clock_i);
    chk(count_o, nr + 3);
    chk(cap1_o, nr + 2);
    tick(1);
    count_edge_i <= EDGE_BOTH;
    cap_i[1]     <= 1'b1;
    tick(2);
    cap_i[1]     <= 1'b0;
    tick(3);
    @(negedge clock_i);
    chk(count_o, nr + 5);
    stop_test();
  end
endmodule
